// File: bench/hpdpc_host_model.sv
// upstream host stand-in: counts the ports it would enumerate, works out its budget
// assumes the hub report is settled when sampled
`timescale 1ns/10ps

module hpdpc_host_model (
	// report from hub
	input  wire hpdpc_pkg::hpdpc_report_t rpt_i,
	// enumeration result
	output logic [2:0]                    enum_count_o,
	output logic [9:0]                    budget_ma_o
);
	always_comb
	begin
		enum_count_o = 3'h0;
		// only mapped host ports can be enumerated
		for (int k = 1; k <= 7; k++)
		begin
			if (rpt_i.host_map[k] != 3'h0)
			begin
				enum_count_o = enum_count_o + 3'h1;
			end
		end
		budget_ma_o = {1'b0, rpt_i.max_power, 1'b0};
	end
endmodule

// File: bench/tb_hub_port_disable_power_config.sv
// self-checking bench for the port disable and power configuration bank
// assumes hpdpc_core as the device and the host stand-in on its report
`timescale 1ns/10ps

module tb_hub_port_disable_power_config;
	logic                     core_clk_i  = 1'b0;
	logic                     nrst_i      = 1'b0;
	logic                     cfg_wr_i    = 1'b0;
	logic [7:0]               cfg_addr_i  = 8'h00;
	logic [7:0]               cfg_wdata_i = 8'h00;
	logic [7:0]               cfg_rdata_o;
	logic                     sp          = 1'b1;
	logic                     rm          = 1'b0;
	logic                     cp          = 1'b0;
	logic                     ud          = 1'b1;
	logic [7:1]               stp         = 7'h00;
	logic [7:1]               stm         = 7'h00;
	hpdpc_pkg::hpdpc_report_t rpt;
	logic [2:0]               enum_cnt;
	logic [9:0]               budget;
	logic [7:0]               msk;
	logic [7:0]               pw_s;
	logic [7:0]               pw_b;
	logic [7:0]               cur;
	logic [7:1]               en;
	logic [7:0]               corner [4] = '{8'hff, 8'h14, 8'h00, 8'h81};
	int                       bad_count   = 0;
	int                       n_tests     = 0;
	int                       cyc         = 0;

	hpdpc_core hpdpc_core_inst (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .self_powered_i(sp), .remap_enable_i(rm),
		.compound_i(cp), .use_defaults_i(ud), .disable_strap_plus_i(stp), .disable_strap_minus_i(stm),
		.report_o(rpt)
	);

	hpdpc_host_model hpdpc_host_model_inst (.rpt_i(rpt), .enum_count_o(enum_cnt), .budget_ma_o(budget));

	always #25 core_clk_i = ~core_clk_i;

	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		cfg_wr_i <= 1'b1;
		cfg_addr_i <= a;
		cfg_wdata_i <= d;
		@(posedge core_clk_i);
		cfg_wr_i <= 1'b0;
	endtask

	// read data is registered: address sampled at one edge, data after it
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
		@(posedge core_clk_i);
		cfg_addr_i <= a;
		@(posedge core_clk_i);
		#1;
		check(cfg_rdata_o, e, what);
	endtask

	function automatic hpdpc_pkg::hpdpc_map_t exp_map(input logic [7:1] v);
		hpdpc_pkg::hpdpc_map_t m;
		int k;
		m = '0;
		k = 1;
		for (int p = 1; p <= 7; p++)
		begin
			if (v[p])
			begin
				m[k] = 3'(p);
				k++;
			end
		end
		return m;
	endfunction

	// hang guard, far above the roughly six hundred cycles the run needs
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'hcbc3));
		stp <= 7'($urandom);
		stm <= 7'($urandom);
		repeat (12) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		ud <= 1'b0;
		rd(8'h0e, 8'h32, "current reset");
		rd(8'h0a, {stp & stm, 1'b0}, "strap sp");
		rd(8'h0b, {stp & stm, 1'b0}, "strap bp");
		wr(8'h0f, 8'hff);
		rd(8'h0f, 8'h00, "unmapped");
		for (int i = 0; i < 24; i++)
		begin
			msk = (i < 4) ? corner[i] : 8'($urandom);
			pw_s = 8'($urandom_range(50));
			pw_b = 8'($urandom);
			cur = 8'($urandom_range(50));
			@(posedge core_clk_i);
			sp <= 1'($urandom);
			rm <= (i < 4) ? 1'b0 : 1'($urandom);
			cp <= 1'($urandom);
			wr(8'h0a, msk);
			wr(8'h0b, ~msk);
			wr(8'h0c, pw_s);
			wr(8'h0d, pw_b);
			wr(8'h0e, cur);
			rd(8'h0a, msk & 8'hfe, "sp mask");
			rd(8'h0b, ~msk & 8'hfe, "bp mask");
			rd(8'h0c, pw_s, "sp power read");
			rd(8'h0d, pw_b, "bp power read");
			rd(8'h0e, cur, "current read");
			repeat (2) @(posedge core_clk_i);
			// look after the edge has settled the registered report
			#1;
			en = rm ? 7'h7f : (sp ? ~msk[7:1] : msk[7:1]);
			check(rpt.port_enabled, en, "enabled");
			check(rpt.port_count, $countones(en), "count");
			check(rpt.host_map, exp_map(en), "map");
			check(enum_cnt, $countones(en), "enumerated");
			check(budget, (sp ? pw_s : pw_b) * hpdpc_pkg::POWER_UNIT_MA, "power");
			check(rpt.ctrl_current, cur, "current");
			check(rpt.compound, cp, "compound");
		end
		// second reset with defaults off: straps ignored, reset values back
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		stp <= 7'h7f;
		stm <= 7'h7f;
		repeat (12) @(posedge core_clk_i);
		#1;
		check({rpt.port_enabled, rpt.port_count, rpt.host_map}, 31'h0, "report in reset");
		check({rpt.max_power, rpt.ctrl_current, rpt.compound}, 17'h0, "power in reset");
		@(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		rd(hpdpc_pkg::OFS_DIS_SP, hpdpc_pkg::RST_DIS_SP, "no strap sp");
		rd(hpdpc_pkg::OFS_DIS_BP, hpdpc_pkg::RST_DIS_BP, "no strap bp");
		rd(hpdpc_pkg::OFS_PWR_SP, hpdpc_pkg::RST_PWR_SP, "sp power reset");
		rd(hpdpc_pkg::OFS_PWR_BP, hpdpc_pkg::RST_PWR_BP, "bp power reset");
		rd(hpdpc_pkg::OFS_CUR_SP, hpdpc_pkg::RST_CUR_SP, "current reset again");
		final_report();
	end
endmodule

// File: hdl/hpdpc_core.sv
// hub port disable / power configuration: register bank and host report
// assumes synchronous byte writes from the eeprom/smbus loader, straps stable at reset
//
// Contract
// RULE1: a set mask bit n disables downstream port n and a clear bit leaves it available.
// RULE2: mask bit zero is reserved and always holds zero.
// RULE3: with remap enable clear the active mask disables its ports permanently for the host.
// RULE4: any pattern of disabled ports is accepted, gaps included.
// RULE5: the reported downstream port count equals the number of enabled ports.
// RULE6: enabled ports are renumbered to a consecutive host sequence.
// RULE7: under default configuration the data-line straps of ports 7..1 pick the disabled ports.
// RULE8: the self-powered mask applies when self-powered, the bus-powered mask otherwise.
// RULE9: the self-powered max power field counts 2 mA units and is reported to the host.
// RULE10: software keeps the self-powered power and current values at or below 100 mA.
// RULE11: the bus-powered max power field counts 2 mA units and is reported as programmed.
// RULE12: the self-powered controller current field counts 2 mA units, hub and board only.
// RULE13: the self-powered controller current resets to 50, meaning 100 mA.
// RULE14: remap enable clear selects standard numbering, set selects re-map mode.
// RULE15: the compound bit makes the hub declare itself part of a compound device.
`timescale 1ns/10ps

module hpdpc_core (
	// clock and reset
	input  wire logic                      core_clk_i,
	input  wire logic                      nrst_i,
	// configuration byte port
	input  wire logic                      cfg_wr_i,
	input  wire logic [7:0]                cfg_addr_i,
	input  wire logic [7:0]                cfg_wdata_i,
	output logic      [7:0]                cfg_rdata_o,
	// mode inputs
	input  wire logic                      self_powered_i,
	input  wire logic                      remap_enable_i,
	input  wire logic                      compound_i,
	input  wire logic                      use_defaults_i,
	// disable straps
	input  wire logic [7:1]                disable_strap_plus_i,
	input  wire logic [7:1]                disable_strap_minus_i,
	// upstream report
	output hpdpc_pkg::hpdpc_report_t       report_o
);

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	logic [7:0] sp_mask_r, sp_mask_nxt;
	logic [7:0] bp_mask_r, bp_mask_nxt;
	logic [7:0] sp_pwr_r,  sp_pwr_nxt;
	logic [7:0] bp_pwr_r,  bp_pwr_nxt;
	logic [7:0] sp_cur_r,  sp_cur_nxt;
	logic       strap_done_r, strap_done_nxt;
	logic [7:0] rdata_r,   rdata_nxt;
	logic [7:1] strap_dis;

	// a port is strapped off only when both of its data lines are pulled up
	assign strap_dis = disable_strap_plus_i & disable_strap_minus_i;

	always_comb
	begin
		sp_mask_nxt    = sp_mask_r;
		bp_mask_nxt    = bp_mask_r;
		sp_pwr_nxt     = sp_pwr_r;
		bp_pwr_nxt     = bp_pwr_r;
		sp_cur_nxt     = sp_cur_r;
		strap_done_nxt = 1'b1;
		// straps caught once, in the first cycle after reset release
		if (!strap_done_r && use_defaults_i)
		begin
			sp_mask_nxt = {strap_dis, 1'b0};             // [RULE7]
			bp_mask_nxt = {strap_dis, 1'b0};             // [RULE7]
		end
		// a loader write in that same cycle wins over the straps
		if (cfg_wr_i)
		begin
			unique case (cfg_addr_i)
				hpdpc_pkg::OFS_DIS_SP: sp_mask_nxt = {cfg_wdata_i[7:1], 1'b0}; // [RULE2]
				hpdpc_pkg::OFS_DIS_BP: bp_mask_nxt = {cfg_wdata_i[7:1], 1'b0}; // [RULE2]
				hpdpc_pkg::OFS_PWR_SP: sp_pwr_nxt  = cfg_wdata_i;             // [RULE9]
				hpdpc_pkg::OFS_PWR_BP: bp_pwr_nxt  = cfg_wdata_i;             // [RULE11]
				hpdpc_pkg::OFS_CUR_SP: sp_cur_nxt  = cfg_wdata_i;             // [RULE12]
				default:               ;
			endcase
		end
		unique case (cfg_addr_i)
			hpdpc_pkg::OFS_DIS_SP: rdata_nxt = sp_mask_r;
			hpdpc_pkg::OFS_DIS_BP: rdata_nxt = bp_mask_r;
			hpdpc_pkg::OFS_PWR_SP: rdata_nxt = sp_pwr_r;
			hpdpc_pkg::OFS_PWR_BP: rdata_nxt = bp_pwr_r;
			hpdpc_pkg::OFS_CUR_SP: rdata_nxt = sp_cur_r;
			default:               rdata_nxt = hpdpc_pkg::RST_RDATA;
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
		begin
			sp_mask_r    <= hpdpc_pkg::RST_DIS_SP;
			bp_mask_r    <= hpdpc_pkg::RST_DIS_BP;
			sp_pwr_r     <= hpdpc_pkg::RST_PWR_SP;
			bp_pwr_r     <= hpdpc_pkg::RST_PWR_BP;
			sp_cur_r     <= hpdpc_pkg::RST_CUR_SP;            // [RULE13]
			strap_done_r <= 1'b0;
			rdata_r      <= hpdpc_pkg::RST_RDATA;
		end
		else
		begin
			sp_mask_r    <= sp_mask_nxt;
			bp_mask_r    <= bp_mask_nxt;
			sp_pwr_r     <= sp_pwr_nxt;
			bp_pwr_r     <= bp_pwr_nxt;
			sp_cur_r     <= sp_cur_nxt;
			strap_done_r <= strap_done_nxt;
			rdata_r      <= rdata_nxt;
		end
	end

	assign cfg_rdata_o = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// active disable set and renumbering
	logic [7:0]            act_mask;
	logic [7:1]            eff_dis;
	hpdpc_pkg::hpdpc_map_t map_c;
	logic [2:0]            count_c;

	assign act_mask = self_powered_i ? sp_mask_r : bp_mask_r;     // [RULE8]
	// re-map mode leaves every port enabled and numbered in place, so the mask is not applied
	assign eff_dis  = remap_enable_i ? 7'h00 : act_mask[7:1];    // [RULE3] [RULE14] [RULE1]

	hpdpc_renum u_renum (
		.disabled_i   (eff_dis),
		.host_map_o   (map_c),
		.port_count_o (count_c)
	);

	////////////////////////////////////////////////////////////////////////
	// registered report towards the host
	hpdpc_pkg::hpdpc_report_t rep_r, rep_nxt;

	always_comb
	begin
		rep_nxt              = rep_r;
		rep_nxt.port_enabled = ~eff_dis;                           // [RULE1]
		rep_nxt.port_count   = count_c;                            // [RULE5]
		rep_nxt.host_map     = map_c;                              // [RULE6]
		// values pass as programmed; their 100 mA ceiling is software's job
		rep_nxt.max_power    = self_powered_i ? sp_pwr_r : bp_pwr_r; // [RULE9] [RULE11]
		rep_nxt.ctrl_current = sp_cur_r;                           // [RULE12]
		rep_nxt.compound     = compound_i;                         // [RULE15]
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!nrst_i)
			rep_r <= '0;
		else
			rep_r <= rep_nxt;
	end

	assign report_o = rep_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	// sampled reset in each antecedent but those of host_order_a and full_map_a: the release edge must not start an attempt
	sequence wr_sp_s;
		nrst_i && cfg_wr_i && cfg_addr_i == hpdpc_pkg::OFS_DIS_SP;
	endsequence

	sequence wr_bp_s;
		nrst_i && cfg_wr_i && cfg_addr_i == hpdpc_pkg::OFS_DIS_BP;
	endsequence

	sequence wr_cur_s;
		nrst_i && cfg_wr_i && cfg_addr_i == hpdpc_pkg::OFS_CUR_SP;
	endsequence

	sequence release_s;
		nrst_i && !$past(nrst_i);
	endsequence

	mask_bit_zero_a: assert property (!sp_mask_r[0] && !bp_mask_r[0]) // [RULE2]
		else $error("reserved mask bit set");

	sp_mask_write_a: assert property (wr_sp_s |=> sp_mask_r == {$past(cfg_wdata_i[7:1]), 1'b0}) // [RULE2]
		else $error("self-powered mask write lost");

	bp_mask_write_a: assert property (wr_bp_s |=> bp_mask_r == {$past(cfg_wdata_i[7:1]), 1'b0}) // [RULE2]
		else $error("bus-powered mask write lost");

	mask_select_a: assert property (nrst_i && !remap_enable_i && self_powered_i |=> // [RULE8]
		report_o.port_enabled == ~$past(sp_mask_r[7:1]))
		else $error("wrong mask applied");

	bp_mask_select_a: assert property (nrst_i && !remap_enable_i && !self_powered_i |=> // [RULE8]
		report_o.port_enabled == ~$past(bp_mask_r[7:1]))
		else $error("wrong bus-powered mask applied");

	remap_mode_a: assert property (nrst_i && remap_enable_i |=> report_o.port_enabled == 7'h7f) // [RULE14]
		else $error("mask applied in remap mode");

	port_count_a: assert property (nrst_i |=> report_o.port_count == // [RULE5]
		3'(7 - $countones($past(eff_dis))))
		else $error("port count mismatch");

	host_order_a: assert property (report_o.port_count >= 3'h2 |-> // [RULE6]
		report_o.host_map[2] > report_o.host_map[1] && report_o.host_map[1] != 3'h0)
		else $error("host numbering not ascending");

	full_map_a: assert property (report_o.port_count == 3'h7 |-> // [RULE6]
		report_o.host_map[7] == 3'h7 && report_o.host_map[1] == 3'h1)
		else $error("full port set not numbered in place");

	strap_load_a: assert property (release_s ##0 (use_defaults_i && !cfg_wr_i) |=> // [RULE7]
		sp_mask_r == {$past(strap_dis), 1'b0} && bp_mask_r == {$past(strap_dis), 1'b0})
		else $error("straps not captured");

	current_reset_a: assert property (release_s |-> sp_cur_r == hpdpc_pkg::RST_CUR_SP) // [RULE13]
		else $error("controller current reset value wrong");

	current_write_a: assert property (wr_cur_s |=> sp_cur_r == $past(cfg_wdata_i)) // [RULE12]
		else $error("controller current write lost");

	sp_power_report_a: assert property (nrst_i && self_powered_i |=> // [RULE9]
		report_o.max_power == $past(sp_pwr_r))
		else $error("self-powered max power not reported");

	power_report_a: assert property (nrst_i && !self_powered_i ##1 !$past(cfg_wr_i) |-> // [RULE11]
		report_o.max_power == bp_pwr_r)
		else $error("bus-powered max power not reported");

	compound_flag_a: assert property (nrst_i && compound_i |=> report_o.compound) // [RULE15]
		else $error("compound flag not reported");

endmodule

// File: hdl/hpdpc_pkg.sv
// hub port disable / power configuration: shared constants and types
// assumes one 20 MHz core clock and byte-wide configuration writes
package hpdpc_pkg;

	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned NUM_PORTS     = 7;

	////////////////////////////////////////////////////////////////////////
	// configuration byte offsets
	localparam logic [7:0] OFS_DIS_SP  = 8'h0a;
	localparam logic [7:0] OFS_DIS_BP  = 8'h0b;
	localparam logic [7:0] OFS_PWR_SP  = 8'h0c;
	localparam logic [7:0] OFS_PWR_BP  = 8'h0d;
	localparam logic [7:0] OFS_CUR_SP  = 8'h0e;

	// reserved mask bit, no port zero exists
	localparam int unsigned MASK_RSVD_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic [7:0] RST_DIS_SP  = 8'h00;
	localparam logic [7:0] RST_DIS_BP  = 8'h00;
	localparam logic [7:0] RST_PWR_SP  = 8'h01;
	localparam logic [7:0] RST_PWR_BP  = 8'h01;
	localparam logic [7:0] RST_CUR_SP  = 8'h32;
	localparam logic [7:0] RST_RDATA   = 8'h00;

	// power and current fields count in this unit
	localparam int unsigned POWER_UNIT_MA = 2;

	////////////////////////////////////////////////////////////////////////
	// figures reported towards the upstream host
	typedef logic [7:1][2:0] hpdpc_map_t;

	typedef struct packed {
		logic [7:1] port_enabled;
		logic [2:0] port_count;
		hpdpc_map_t host_map;
		logic [7:0] max_power;
		logic [7:0] ctrl_current;
		logic       compound;
	} hpdpc_report_t;

	// number of set bits among ports 7..1
	function automatic logic [2:0] ones7(input logic [7:1] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 1; i <= 7; i++)
		begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction

endpackage

// File: hdl/hpdpc_renum.sv
// hub port disable / power configuration: port renumbering network
// assumes a disable vector for physical ports 7..1; purely combinational
`timescale 1ns/10ps

module hpdpc_renum (
	// physical side
	input  wire logic [7:1]          disabled_i,
	// host-visible side
	output hpdpc_pkg::hpdpc_map_t    host_map_o,
	output logic      [2:0]          port_count_o
);

	logic       [2:0] cnt;
	hpdpc_pkg::hpdpc_map_t map;

	// k-th enabled physical port becomes host port k; gaps are allowed
	always_comb
	begin
		cnt = 3'h0;
		map = '0;
		for (int p = 1; p <= 7; p++)
		begin
			if (!disabled_i[p])
			begin
				cnt      = cnt + 3'h1;                // [RULE4]
				map[cnt] = 3'(p);                     // [RULE6]
			end
		end
	end

	assign host_map_o   = map;
	assign port_count_o = hpdpc_pkg::ones7(~disabled_i); // [RULE5]

endmodule
